// ---- logic/cd_hotplug_defs.vh ----
// Constants for the cable-detect and hot-plug block.
// Assumes a single 25 MHz system clock and byte-wide register maps.
//
// Contract
// [R01] Read-only raw port A cable bit
// [R02] Raw readback valid in any mode
// [R03] Filter high only after full qualified time
// [R04] Any input change drops filter, restarts count
// [R05] Filtered detect drives reset and flag
// [R06] Deglitch disable bit bypasses the filter
// [R07] Filter runs on its own oscillator tick; here a two-cycle clk_sys divider stands in
// [R08] Duration counts 47 ns units, default 0x58; the code counts 2-cycle units of 80 ns
// [R09] Inhibit 0: hold HDMI reset when unplugged
// [R10] Inhibit 1: sense pin never resets HDMI
// [R11] Host sets inhibit when pin unconnected
// [R12] Drive hot-plug output toward the source
// [R13] Manual enable selects manual or automatic source
// [R14] Manual level 0 drives low, 1 releases
// [R15] Auto: assert after delay, drop immediately; policy 00 follows edidActive alone, with no delay and no drop on unplug
// [R16] Delay select in 100 ms steps, default 1 s
// [R17] Two-flop synchroniser before deglitch counter
// [R18] Filtered results synchronised before status use
`ifndef CD_HOTPLUG_DEFS_VH
`define CD_HOTPLUG_DEFS_VH

// ============================================================
// Register map selection
`define CD_MAP_IO 1'b0
`define CD_MAP_HDMI 1'b1

// ============================================================
// HDMI map offsets and fields
`define CD_ADDR_RST_INHIBIT 8'h48
`define CD_BIT_RST_INHIBIT 6
`define CD_ADDR_DEGLITCH 8'h56
`define CD_BIT_DEGLITCH_DIS 7
`define CD_RST_DEGLITCH_DUR 7'h58
`define CD_ADDR_HPD_CTRL 8'h6C
`define CD_BIT_HPD_MANUAL 0
`define CD_RST_HPD_POLICY 2'h1
`define CD_RST_HPD_DELAY 4'hA

// ============================================================
// IO map offsets and fields
`define CD_ADDR_HPD_MANUAL 8'h20
`define CD_BIT_HPD_LEVEL 7
`define CD_BIT_HPD_TRISTATE 3
`define CD_ADDR_HPD_STATUS 8'h21
`define CD_BIT_HPD_STATUS 3
`define CD_ADDR_CABLE_RAW 8'h6F

// ============================================================
// Automatic hot-plug policies
`define CD_POL_EDID 2'h0
`define CD_POL_DELAY 2'h1
`define CD_POL_EDID_CABLE 2'h2
`define CD_POL_ALL 2'h3

// ============================================================
// Timing
`define CD_CLK_PERIOD_NS 40
`define CD_CLK_KHZ 25000
`define CD_UNIT_NS 47
`define CD_UNIT_CYCLES ((`CD_UNIT_NS + `CD_CLK_PERIOD_NS - 1) / `CD_CLK_PERIOD_NS)
`define CD_HPD_STEP_MS 100
`define CD_HPD_STEP_CYCLES (`CD_HPD_STEP_MS * `CD_CLK_KHZ)

`endif

// ---- logic/cd_deglitch.v ----
// Deglitch filter for the power-sense pin.
// Assumes the pin is asynchronous; everything else on clk_sys.
`timescale 1ns/1ps
`default_nettype none
`include "cd_hotplug_defs.vh"

module cd_deglitch #(
    parameter DUR_W = 7,
    parameter UNIT_CYCLES = `CD_UNIT_CYCLES
) (
    // Clock and reset
    input wire clk_sys,
    input wire reset,
    // Sense pin and controls
    input wire senseIn,
    input wire filterDisable,
    input wire [DUR_W-1:0] duration,
    // Results
    output wire senseSync,
    output reg filtered_q
);

    // ============================================================
    // Synchroniser: first stage read only by the second
    reg sync1_q; // Metastable stage
    reg sync2_q; // Stable sampled level
    reg prev_q; // Last stable level, for change detection
    reg [3:0] tickCnt_q; // Unit divider
    reg [DUR_W-1:0] unitCnt_q; // Qualified units so far
    wire unitTick;
    wire changed;

    assign senseSync = sync2_q;
    assign changed = sync2_q != prev_q;
    assign unitTick = tickCnt_q == (UNIT_CYCLES - 1);

    // Two flops before any use
    always @(posedge clk_sys)
    begin
        if (reset)
        begin
            sync1_q <= 1'b0;
            sync2_q <= 1'b0;
            prev_q <= 1'b0;
        end
        else
        begin
            sync1_q <= senseIn; // [R17]
            sync2_q <= sync1_q; // [R17]
            prev_q <= sync2_q;
        end
    end

    // ============================================================
    // Unit tick stands in for the oscillator's two-cycle unit
    always @(posedge clk_sys)
    begin
        if (reset || changed)
            tickCnt_q <= 4'h0;
        else if (unitTick)
            tickCnt_q <= 4'h0; // [R07]
        else
            tickCnt_q <= tickCnt_q + 4'h1;
    end

    // ============================================================
    // Qualification counter and output
    always @(posedge clk_sys)
    begin
        if (reset)
        begin
            unitCnt_q <= {DUR_W{1'b0}};
            filtered_q <= 1'b0;
        end
        else if (filterDisable)
        begin
            // Bypass: follow the synchronised level
            unitCnt_q <= {DUR_W{1'b0}};
            filtered_q <= sync2_q; // [R06]
        end
        else if (changed || !sync2_q)
        begin
            // Any edge drops the output and restarts
            unitCnt_q <= {DUR_W{1'b0}}; // [R04]
            filtered_q <= 1'b0; // [R04]
        end
        else if (unitCnt_q >= duration)
            filtered_q <= 1'b1; // [R03] [R08]
        else if (unitTick)
            unitCnt_q <= unitCnt_q + {{(DUR_W-1){1'b0}}, 1'b1}; // [R08]
    end

endmodule
`default_nettype wire

// ---- logic/cd_hotplug_ctrl.v ----
// Cable detect and hot-plug controller, register side and policy.
// Assumes an external serial slave turns bus cycles into the
// byte-wide register port below; pin inputs are asynchronous.
// The hot-plug pin is open drain: a board pull-up gives the
// released level, so the block only ever pulls it low.
`timescale 1ns/1ps
`default_nettype none
`include "cd_hotplug_defs.vh"

module cd_hotplug_ctrl #(
    parameter STEP_CYCLES = `CD_HPD_STEP_CYCLES
) (
    // Clock and reset
    input wire clk_sys,
    input wire reset,
    // Register port
    input wire regMap,
    input wire [7:0] regAddr,
    input wire regWrEn,
    input wire [7:0] regWrData,
    output reg [7:0] regRdData_q,
    // Pins and system
    input wire port_a_power_sense_pin,
    input wire edidActive,
    output wire hotplug_pin_a_o,
    output wire hotplug_pin_a_oe,
    output wire cableDetFlag,
    output wire hdmiResetReq
);

    // ============================================================
    // Control registers
    // Written only through the register port; reset to defaults
    reg cable_reset_inhibit_q; // Keeps sense pin out of reset
    reg deglitch_disable_q; // Filter bypass
    reg [6:0] deglitch_duration_q; // Units of two osc cycles
    reg hotplug_manual_enable_q; // Manual source select
    reg [1:0] hotplug_auto_policy_q; // Automatic policy
    reg [3:0] hotplug_delay_select_q; // 100 ms steps
    reg hotplug_manual_level_a_q; // Manual pin level
    reg hotplugTristate_q; // Releases the pin entirely
    // Policy state
    // Step counter is wide enough for one default step at the
    // system clock rate
    reg [21:0] stepCnt_q; // Cycles within one step
    reg [3:0] stepsDone_q; // Steps elapsed since plug
    reg hotplug_assert_q; // Registered pin state
    reg [7:0] rdNext;
    // Filter results and decoded controls
    wire senseSync;
    wire filtered;
    wire delayDone;
    wire autoLevel;
    wire wrHdmi;
    wire wrIo;

    // Write strobes split by map; the map bit is a plain level
    // held with the address for the whole access
    assign wrHdmi = regWrEn && (regMap == `CD_MAP_HDMI);
    assign wrIo = regWrEn && (regMap == `CD_MAP_IO);

    // ============================================================
    // Deglitch filter instance
    // The filter owns the two-flop synchroniser, so nothing here
    // reads the raw pin directly
    cd_deglitch #(
        .DUR_W(7)
    ) u_filt (
        .clk_sys(clk_sys),
        .reset(reset),
        .senseIn(port_a_power_sense_pin),
        .filterDisable(deglitch_disable_q),
        .duration(deglitch_duration_q),
        .senseSync(senseSync),
        .filtered_q(filtered)
    );

    // Filtered level is already registered in this clock domain
    // Level only; whoever raises the interrupt latches its edges
    assign cableDetFlag = filtered; // [R05] [R18]
    // Reset request only while not inhibited
    assign hdmiResetReq = !cable_reset_inhibit_q && !filtered; // [R05] [R09] [R10]

    // ============================================================
    // Register writes
    // One write per strobe; read-only and unmapped offsets fall
    // through every branch and are ignored
    always @(posedge clk_sys)
    begin
        if (reset)
        begin
            cable_reset_inhibit_q <= 1'b0;
            deglitch_disable_q <= 1'b0;
            deglitch_duration_q <= `CD_RST_DEGLITCH_DUR;
            hotplug_manual_enable_q <= 1'b0;
            hotplug_auto_policy_q <= `CD_RST_HPD_POLICY;
            hotplug_delay_select_q <= `CD_RST_HPD_DELAY;
            hotplug_manual_level_a_q <= 1'b1;
            hotplugTristate_q <= 1'b0;
        end
        else if (wrHdmi)
        begin
            // HDMI map: inhibit, filter and hot-plug control
            if (regAddr == `CD_ADDR_RST_INHIBIT)
                cable_reset_inhibit_q <= regWrData[`CD_BIT_RST_INHIBIT];
            else if (regAddr == `CD_ADDR_DEGLITCH)
            begin
                deglitch_disable_q <= regWrData[`CD_BIT_DEGLITCH_DIS];
                deglitch_duration_q <= regWrData[6:0];
            end
            else if (regAddr == `CD_ADDR_HPD_CTRL)
            begin
                hotplug_delay_select_q <= regWrData[7:4];
                hotplug_auto_policy_q <= regWrData[2:1];
                hotplug_manual_enable_q <= regWrData[`CD_BIT_HPD_MANUAL];
            end
        end
        else if (wrIo && (regAddr == `CD_ADDR_HPD_MANUAL))
        begin
            // IO map: manual level and pin release
            hotplug_manual_level_a_q <= regWrData[`CD_BIT_HPD_LEVEL];
            hotplugTristate_q <= regWrData[`CD_BIT_HPD_TRISTATE];
        end
    end

    // ============================================================
    // Read mux; other bits and unmapped offsets read zero
    // Combinational here; the register below adds the one-cycle lag
    always @*
    begin
        rdNext = 8'h00;
        if (regMap == `CD_MAP_HDMI)
        begin
            // HDMI map control fields
            if (regAddr == `CD_ADDR_RST_INHIBIT)
                rdNext[`CD_BIT_RST_INHIBIT] = cable_reset_inhibit_q;
            else if (regAddr == `CD_ADDR_DEGLITCH)
                rdNext = {deglitch_disable_q, deglitch_duration_q};
            else if (regAddr == `CD_ADDR_HPD_CTRL)
                rdNext = {hotplug_delay_select_q, 1'b0, hotplug_auto_policy_q,
                          hotplug_manual_enable_q};
        end
        else
        begin
            // IO map; status bits are read only
            if (regAddr == `CD_ADDR_HPD_MANUAL)
            begin
                rdNext[`CD_BIT_HPD_LEVEL] = hotplug_manual_level_a_q;
                rdNext[`CD_BIT_HPD_TRISTATE] = hotplugTristate_q;
            end
            else if (regAddr == `CD_ADDR_HPD_STATUS)
                rdNext[`CD_BIT_HPD_STATUS] = hotplug_assert_q;
            else if (regAddr == `CD_ADDR_CABLE_RAW)
                rdNext[0] = senseSync; // [R01] [R02]
        end
    end

    // Read data registered, one cycle after the address
    // Costs a cycle of latency but keeps the mux off the bus path
    always @(posedge clk_sys)
    begin
        if (reset)
            regRdData_q <= 8'h00;
        else
            regRdData_q <= rdNext;
    end

    // ============================================================
    // Plug-to-assert delay; restarts whenever the cable drops
    // Held clear while unplugged, so a quick reconnect still waits
    // the whole programmed delay
    assign delayDone = stepsDone_q >= hotplug_delay_select_q; // [R16]

    always @(posedge clk_sys)
    begin
        if (reset || !filtered)
        begin
            // Restart on reset or unplug
            stepCnt_q <= 22'h000000;
            stepsDone_q <= 4'h0;
        end
        else if (!delayDone)
        begin
            // Long count; shorten STEP_CYCLES in simulation
            if (stepCnt_q == STEP_CYCLES - 1)
            begin
                stepCnt_q <= 22'h000000;
                stepsDone_q <= stepsDone_q + 4'h1; // [R16]
            end
            else
                stepCnt_q <= stepCnt_q + 22'h000001;
        end
    end

    // ============================================================
    // Automatic policy and source select
    // Policy 00 follows the EDID enable alone, policy 01 the delayed
    // detect alone; policy 10 needs both, and policy 11 the manual level as well
    assign autoLevel =
        (hotplug_auto_policy_q == `CD_POL_EDID) ? edidActive :
        (hotplug_auto_policy_q == `CD_POL_DELAY) ? (filtered && delayDone) : // [R15]
        (hotplug_auto_policy_q == `CD_POL_EDID_CABLE) ?
            (edidActive && filtered && delayDone) :
            (edidActive && filtered && delayDone && hotplug_manual_level_a_q);

    always @(posedge clk_sys)
    begin
        if (reset)
            hotplug_assert_q <= 1'b0;
        // Manual mode wins over every automatic policy
        else if (hotplug_manual_enable_q)
            hotplug_assert_q <= hotplug_manual_level_a_q; // [R13] [R14]
        else
            hotplug_assert_q <= autoLevel; // [R13] [R15]
    end

    // Open drain: pull low when deasserted and not tristated, release otherwise
    // The data side is tied low and only the enable moves, so the
    // pin is never driven high against the pull-up
    assign hotplug_pin_a_o = 1'b0; // [R12]
    assign hotplug_pin_a_oe = !hotplug_assert_q && !hotplugTristate_q; // [R12] [R14]

endmodule
`default_nettype wire

// ---- sim/cd_hotplug_props.sv ----
// Checker for the cable-detect and hot-plug controller ports.
// Assumes a single clock; register shadows follow bus writes.
`timescale 1ns/1ps
`default_nettype none
module cd_hotplug_props #(
    parameter STEP_CYCLES = 10
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic reset,
    // Register port
    input wire logic regMap,
    input wire logic [7:0] regAddr,
    input wire logic regWrEn,
    input wire logic [7:0] regWrData,
    input wire logic [7:0] regRdData_q,
    // Pins and system
    input wire logic port_a_power_sense_pin,
    input wire logic edidActive,
    input wire logic hotplug_pin_a_o,
    input wire logic hotplug_pin_a_oe,
    input wire logic cableDetFlag,
    input wire logic hdmiResetReq
);
    // ==========================================
    // Shadow registers and run-length counters
    logic inh_q, dis_q, man_q, lvl_q;
    logic [6:0] dur_q;
    logic [3:0] sel_q;
    logic [1:0] pol_q;
    logic [15:0] highCnt_q, flagCnt_q;
    always @(posedge clk_sys)
    begin
        // Counters saturate so long runs never wrap
        highCnt_q <= !port_a_power_sense_pin ? 16'h0 : highCnt_q + {15'h0, ~&highCnt_q};
        flagCnt_q <= !cableDetFlag ? 16'h0 : flagCnt_q + {15'h0, ~&flagCnt_q};
        if (reset)
        begin
            {inh_q, dis_q, dur_q, man_q, sel_q, lvl_q} <= {2'h0, 7'h58, 1'h0, 4'hA, 1'h1};
            pol_q <= 2'h1;
        end
        else if (regWrEn)
        begin
            if (regMap && regAddr == 8'h48) inh_q <= regWrData[6];
            if (regMap && regAddr == 8'h56) {dis_q, dur_q} <= regWrData;
            if (regMap && regAddr == 8'h6C)
                {sel_q, pol_q, man_q} <= {regWrData[7:4], regWrData[2:0]};
            if (!regMap && regAddr == 8'h20) lvl_q <= regWrData[7];
        end
    end
    default clocking @(posedge clk_sys); endclocking
    default disable iff (reset);
    // ==========================================
    // Properties
    reset_state_a: assert property (disable iff (1'b0) reset |=> hotplug_pin_a_oe
        && !cableDetFlag && hdmiResetReq) else $error("bad state after reset");
    open_drain_a: assert property (hotplug_pin_a_o == 1'b0)
        else $error("hot-plug output driven high");
    raw_read_a: assert property (($stable(port_a_power_sense_pin))[*4] ##0
        (!regMap && regAddr == 8'h6F) |=> regRdData_q[0] == $past(port_a_power_sense_pin))
        else $error("raw cable bit wrong");
    qualify_time_a: assert property ($rose(cableDetFlag) && !dis_q
        |-> highCnt_q >= 2 * dur_q + 2) else $error("flag rose too early");
    change_drop_a: assert property ($changed(port_a_power_sense_pin)
        |-> ##[1:5] !cableDetFlag) else $error("flag kept after pin change");
    inhibit_off_a: assert property (inh_q |-> !hdmiResetReq)
        else $error("reset despite inhibit");
    unplug_reset_a: assert property (!inh_q && !cableDetFlag && !$past(cableDetFlag)
        |-> hdmiResetReq) else $error("no reset while unplugged");
    manual_level_a: assert property ($past(man_q) && man_q
        |-> hotplug_pin_a_oe == !$past(lvl_q)) else $error("manual level not applied");
    auto_delay_a: assert property (!man_q && pol_q != 2'h0
        && $fell(hotplug_pin_a_oe) |-> flagCnt_q >= sel_q * STEP_CYCLES)
        else $error("hot-plug asserted early");
    auto_drop_a: assert property (!man_q && !$past(man_q) && pol_q != 2'h0
        && !cableDetFlag |-> ##[1:2] hotplug_pin_a_oe) else $error("hot-plug not dropped");
endmodule
`default_nettype wire

// ---- sim/cd_source_model.sv ----
// Source-side model: drives the power-sense pin, sees the hot-plug wire.
// Assumes the hot-plug wire carries a pull-up, as an open-drain line needs.
`timescale 1ns/1ps
`default_nettype none
module cd_source_model (
    // Cable command from the bench
    input wire logic plugged,
    // Open-drain hot-plug pin
    input wire logic hotplug_pin_a_o,
    input wire logic hotplug_pin_a_oe,
    // Wire levels
    output logic senseOut,
    output logic hpdSeen
);
    // Sense pin follows the cable, glitches included
    assign senseOut = plugged;
    // Released wire rises through the pull-up
    assign hpdSeen = hotplug_pin_a_oe ? hotplug_pin_a_o : 1'b1;
endmodule
`default_nettype wire

// ---- sim/cd_hotplug_ctrl_test.sv ----
// Testbench for the cable-detect and hot-plug controller.
// Assumes the source model and checker files compile first.
`timescale 1ns/1ps
`default_nettype none
module cd_hotplug_ctrl_test;
    // ==========================================
    // Stimulus and observed signals
    logic clk_sys = 0;
    logic reset = 1;
    logic regMap = 0;
    logic [7:0] regAddr = 8'h00;
    logic regWrEn = 0;
    logic [7:0] regWrData = 8'h00;
    logic plugged = 0;
    logic edidActive = 0;
    logic senseLine, hpdSeen, pinO, pinOe, cableDetFlag, hdmiResetReq;
    logic [7:0] regRdData_q;
    int miscompares = 0;
    int n_compared = 0;
    always #20 clk_sys = ~clk_sys;
    // Short step keeps the hot-plug delay test brief
    cd_hotplug_ctrl #(.STEP_CYCLES(10)) DUT (.clk_sys(clk_sys), .reset(reset),
        .regMap(regMap), .regAddr(regAddr), .regWrEn(regWrEn), .regWrData(regWrData),
        .regRdData_q(regRdData_q), .port_a_power_sense_pin(senseLine),
        .edidActive(edidActive), .hotplug_pin_a_o(pinO), .hotplug_pin_a_oe(pinOe),
        .cableDetFlag(cableDetFlag), .hdmiResetReq(hdmiResetReq));
    cd_source_model SRC (.plugged(plugged), .hotplug_pin_a_o(pinO),
        .hotplug_pin_a_oe(pinOe), .senseOut(senseLine), .hpdSeen(hpdSeen));
    // ==========================================
    // Access and check tasks
    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        n_compared++;
        if (got !== exp)
        begin
            miscompares++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wr(input logic m, input logic [7:0] a, input logic [7:0] d);
        tick(1);
        {regMap, regAddr, regWrData, regWrEn} = {m, a, d, 1'b1};
        tick(1);
        regWrEn = 0;
    endtask
    task automatic rd(input logic m, input logic [7:0] a, input logic [7:0] mask,
        input logic [7:0] exp, input string what);
        {regMap, regAddr} = {m, a};
        tick(2);
        chk(what, exp & mask, regRdData_q & mask);
    endtask
    // Bounded wait on the flag or the hot-plug wire, timed in cycles
    task automatic waitSig(input bit useHpd, input logic val, input int lo, input int hi,
        input string what);
        int n;
        n = 0;
        while ((useHpd ? hpdSeen : cableDetFlag) !== val && n < hi)
        begin
            tick(1);
            n++;
        end
        n_compared++;
        if (n < lo || n >= hi)
        begin
            miscompares++;
            $display("[ERR] %s expected %0d to %0d cycles seen %0d", what, lo, hi, n);
        end
        if (n >= hi) conclude();
    endtask
    task automatic conclude();
        $display("compared %0d miscompares %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    // ==========================================
    // Test sequence
    initial
    begin
        tick(20);
        reset = 0;
        rd(1, 8'h48, 8'h40, 8'h00, "inhibit");
        rd(1, 8'h56, 8'hFF, 8'h58, "deglitch");
        rd(1, 8'h6C, 8'hF7, 8'hA2, "hpd ctrl");
        rd(0, 8'h20, 8'h88, 8'h80, "manual level");
        rd(1, 8'h00, 8'hFF, 8'h00, "unmapped");
        wr(0, 8'h6F, 8'hFF);
        rd(0, 8'h6F, 8'h01, 8'h00, "raw idle");
        chk("reset req", 8'h01, 8'(hdmiResetReq));
        $display("test defaults done");
        wr(1, 8'h56, 8'h05);
        plugged = 1;
        waitSig(0, 1, 12, 22, "qualify");
        rd(0, 8'h6F, 8'h01, 8'h01, "raw plugged");
        chk("reset req", 8'h00, 8'(hdmiResetReq));
        plugged = 0;
        tick(1);
        plugged = 1;
        waitSig(0, 0, 0, 5, "glitch drop");
        waitSig(0, 1, 8, 22, "requalify");
        plugged = 0;
        waitSig(0, 0, 0, 6, "unplug");
        chk("reset req", 8'h01, 8'(hdmiResetReq));
        $display("test filter done");
        wr(1, 8'h56, 8'hFF);
        rd(1, 8'h56, 8'hFF, 8'hFF, "deglitch rw");
        plugged = 1;
        waitSig(0, 1, 1, 6, "bypass");
        plugged = 0;
        waitSig(0, 0, 0, 6, "bypass drop");
        wr(1, 8'h48, 8'h40);
        tick(1);
        chk("inhibited", 8'h00, 8'(hdmiResetReq));
        wr(1, 8'h48, 8'h00);
        $display("test bypass done");
        wr(1, 8'h56, 8'h05);
        wr(1, 8'h6C, 8'h12);
        plugged = 1;
        waitSig(0, 1, 12, 22, "qualify");
        chk("hpd held", 8'h00, 8'(hpdSeen));
        waitSig(1, 1, 9, 14, "hpd delay");
        rd(0, 8'h21, 8'h08, 8'h08, "hpd status");
        plugged = 0;
        waitSig(1, 0, 0, 6, "hpd drop");
        $display("test auto done");
        wr(1, 8'h6C, 8'h00);
        edidActive = 1;
        waitSig(1, 1, 1, 4, "edid assert");
        edidActive = 0;
        waitSig(1, 0, 1, 4, "edid drop");
        $display("test edid done");
        wr(1, 8'h6C, 8'h13);
        wr(0, 8'h20, 8'h00);
        tick(1);
        chk("manual low", 8'h00, 8'(hpdSeen));
        wr(0, 8'h20, 8'h80);
        tick(1);
        chk("manual high", 8'h01, 8'(hpdSeen));
        $display("test manual done");
        conclude();
    end
endmodule
bind cd_hotplug_ctrl cd_hotplug_props #(.STEP_CYCLES(STEP_CYCLES)) PROPS (.clk_sys(clk_sys),
    .reset(reset), .regMap(regMap), .regAddr(regAddr), .regWrEn(regWrEn),
    .regWrData(regWrData), .regRdData_q(regRdData_q),
    .port_a_power_sense_pin(port_a_power_sense_pin), .edidActive(edidActive),
    .hotplug_pin_a_o(hotplug_pin_a_o), .hotplug_pin_a_oe(hotplug_pin_a_oe),
    .cableDetFlag(cableDetFlag), .hdmiResetReq(hdmiResetReq));
`default_nettype wire
